// ### design/oad_decoder.sv
// Operand address decoder: form byte, displacement, offset and segment choice
`timescale 1ns/1ps
module oad_decoder (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic decode_start,
  input wire logic [7:0] form_byte,
  input wire logic size_word,
  input wire logic string_dest,
  input wire logic prefix_valid,
  input wire logic [7:0] prefix_byte,
  input wire logic disp_valid,
  input wire logic [7:0] disp_byte,
  input wire logic [15:0] accumulator_word,
  input wire logic [15:0] count_word,
  input wire logic [15:0] data_word,
  input wire logic [15:0] base_general_word,
  input wire logic [15:0] stack_pointer_word,
  input wire logic [15:0] base_pointer_word,
  input wire logic [15:0] source_index_word,
  input wire logic [15:0] destination_index_word,
  output logic busy,
  output logic disp_ready,
  output logic result_valid,
  output logic operand_is_register,
  output logic [15:0] operand_offset,
  output logic [15:0] operand_value,
  output logic [1:0] segment_sel,
  output logic override_held
);

  oad_gpr_if gpr ();

  oad_reg_select oad_reg_select_inst (
    .gpr(gpr)
  );

  oad_pkg::oad_state_t state, next_state;
  logic [1:0] form, next_form;
  logic [2:0] sel, next_sel;
  logic str_q, next_str_q;
  logic [7:0] disp_low, next_disp_low;
  logic [7:0] disp_high, next_disp_high;
  logic [2:0] calc_left, next_calc_left;
  logic [1:0] ovr_seg, next_ovr_seg;
  logic next_override_held;
  logic next_busy;
  logic next_disp_ready;
  logic next_result_valid;
  logic next_operand_is_register;
  logic [15:0] next_operand_offset;
  logic [15:0] next_operand_value;
  logic [1:0] next_segment_sel;
  logic [15:0] disp_word;
  logic [15:0] offset_sum;
  logic direct;
  logic via_bp;
  logic prefix_hit;
  logic disp_take;

  assign gpr.accumulator_word = accumulator_word;
  assign gpr.count_word = count_word;
  assign gpr.data_word = data_word;
  assign gpr.base_general_word = base_general_word;
  assign gpr.stack_pointer_word = stack_pointer_word;
  assign gpr.base_pointer_word = base_pointer_word;
  assign gpr.source_index_word = source_index_word;
  assign gpr.destination_index_word = destination_index_word;
  assign gpr.slot = form_byte[oad_pkg::SEL_MSB:oad_pkg::SEL_LSB];
  assign gpr.size_word = size_word;

  // ----------------------------------------------------------------
  // Offset arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    direct = (form == oad_pkg::FORM_NO_DISP) && (sel == oad_pkg::SEL_BP);
    unique case (form)
      oad_pkg::FORM_DISP8: disp_word = {{8{disp_low[7]}}, disp_low};
      oad_pkg::FORM_DISP16: disp_word = {disp_high, disp_low};
      default: disp_word = 16'h0000;
    endcase
    // Plain 16-bit adds wrap on their own; no carry is kept
    unique case (sel)
      oad_pkg::SEL_BASE_SRC:
        offset_sum = base_general_word + source_index_word + disp_word;
      oad_pkg::SEL_BASE_DST:
        offset_sum = base_general_word + destination_index_word + disp_word;
      oad_pkg::SEL_BP_SRC:
        offset_sum = base_pointer_word + source_index_word + disp_word;
      oad_pkg::SEL_BP_DST:
        offset_sum = base_pointer_word + destination_index_word + disp_word;
      oad_pkg::SEL_SRC: offset_sum = source_index_word + disp_word;
      oad_pkg::SEL_DST: offset_sum = destination_index_word + disp_word;
      oad_pkg::SEL_BP: begin
        if (direct) begin
          offset_sum = {disp_high, disp_low};
        end else begin
          offset_sum = base_pointer_word + disp_word;
        end
      end
      oad_pkg::SEL_BASE: offset_sum = base_general_word + disp_word;
    endcase
    via_bp = !direct && ((sel == oad_pkg::SEL_BP_SRC) || (sel == oad_pkg::SEL_BP_DST) ||
                         (sel == oad_pkg::SEL_BP));
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_form = form;
    next_sel = sel;
    next_str_q = str_q;
    next_disp_low = disp_low;
    next_disp_high = disp_high;
    next_calc_left = calc_left;
    next_ovr_seg = ovr_seg;
    next_override_held = override_held;
    next_result_valid = 1'b0;
    next_operand_is_register = operand_is_register;
    next_operand_offset = operand_offset;
    next_operand_value = operand_value;
    next_segment_sel = segment_sel;
    disp_take = disp_valid && disp_ready;
    prefix_hit = prefix_valid &&
                 (prefix_byte[7:5] == oad_pkg::PREFIX_TOP) &&
                 (prefix_byte[2:0] == oad_pkg::PREFIX_LOW);
    if (prefix_hit && (state == oad_pkg::OAD_IDLE) && !decode_start) begin
      next_ovr_seg = prefix_byte[oad_pkg::PREFIX_SEG_MSB:oad_pkg::PREFIX_SEG_LSB];
      next_override_held = 1'b1;
    end
    unique case (state)
      oad_pkg::OAD_IDLE: begin
        if (decode_start) begin
          next_form = form_byte[oad_pkg::FORM_MSB:oad_pkg::FORM_LSB];
          next_sel = form_byte[oad_pkg::SEL_MSB:oad_pkg::SEL_LSB];
          next_str_q = string_dest;
          next_disp_low = oad_pkg::BYTE_RESET;
          next_disp_high = oad_pkg::BYTE_RESET;
          next_calc_left = oad_pkg::CALC_CYCLES;
          if (form_byte[7:6] == oad_pkg::FORM_REG) begin
            // Register operand: answered next cycle, segment untouched
            next_operand_is_register = 1'b1;
            next_operand_value = gpr.value;
            next_result_valid = 1'b1;
            next_override_held = 1'b0;
          end else if ((form_byte[7:6] == oad_pkg::FORM_NO_DISP) &&
                       (form_byte[2:0] != oad_pkg::SEL_BP)) begin
            next_state = oad_pkg::OAD_CALC;
          end else begin
            next_state = oad_pkg::OAD_DISP_LOW;
          end
        end
      end
      oad_pkg::OAD_DISP_LOW: begin
        if (disp_take) begin
          next_disp_low = disp_byte;
          if (form == oad_pkg::FORM_DISP8) begin
            next_state = oad_pkg::OAD_CALC;
          end else begin
            next_state = oad_pkg::OAD_DISP_HIGH;
          end
        end
      end
      oad_pkg::OAD_DISP_HIGH: begin
        if (disp_take) begin
          next_disp_high = disp_byte;
          next_state = oad_pkg::OAD_CALC;
        end
      end
      oad_pkg::OAD_CALC: begin
        next_calc_left = calc_left - 3'h1;
        if (calc_left == 3'h1) begin
          next_state = oad_pkg::OAD_IDLE;
          next_result_valid = 1'b1;
          next_operand_is_register = 1'b0;
          next_operand_offset = offset_sum;
          next_override_held = 1'b0;
          // String destination beats any override; override beats defaults
          if (str_q) begin
            next_segment_sel = oad_pkg::OAD_SEG_EXTRA;
          end else if (override_held) begin
            next_segment_sel = ovr_seg;
          end else if (via_bp) begin
            next_segment_sel = oad_pkg::OAD_SEG_STACK;
          end else begin
            next_segment_sel = oad_pkg::OAD_SEG_DATA;
          end
        end
      end
    endcase
    next_busy = (next_state != oad_pkg::OAD_IDLE);
    next_disp_ready = (next_state == oad_pkg::OAD_DISP_LOW) ||
                      (next_state == oad_pkg::OAD_DISP_HIGH);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= oad_pkg::OAD_IDLE;
      form <= oad_pkg::FORM_NO_DISP;
      sel <= oad_pkg::SEL_BASE_SRC;
      str_q <= 1'b0;
      disp_low <= oad_pkg::BYTE_RESET;
      disp_high <= oad_pkg::BYTE_RESET;
      calc_left <= oad_pkg::CALC_CYCLES;
      ovr_seg <= oad_pkg::OAD_SEG_DATA;
      override_held <= 1'b0;
      busy <= 1'b0;
      disp_ready <= 1'b0;
      result_valid <= 1'b0;
      operand_is_register <= 1'b0;
      operand_offset <= oad_pkg::OFFSET_RESET;
      operand_value <= oad_pkg::OFFSET_RESET;
      segment_sel <= oad_pkg::OAD_SEG_DATA;
    end else begin
      state <= next_state;
      form <= next_form;
      sel <= next_sel;
      str_q <= next_str_q;
      disp_low <= next_disp_low;
      disp_high <= next_disp_high;
      calc_left <= next_calc_left;
      ovr_seg <= next_ovr_seg;
      override_held <= next_override_held;
      busy <= next_busy;
      disp_ready <= next_disp_ready;
      result_valid <= next_result_valid;
      operand_is_register <= next_operand_is_register;
      operand_offset <= next_operand_offset;
      operand_value <= next_operand_value;
      segment_sel <= next_segment_sel;
    end
  end

endmodule : oad_decoder

// ### design/oad_reg_select.sv
// Register operand selector for word and byte operand slots
`timescale 1ns/1ps
module oad_reg_select (
  oad_gpr_if.sel gpr
);

  logic [7:0] low_byte;

  always_comb begin
    low_byte = 8'h00;
    gpr.value = 16'h0000;
    if (gpr.size_word) begin
      unique case (gpr.slot)
        3'h0: gpr.value = gpr.accumulator_word;
        3'h1: gpr.value = gpr.count_word;
        3'h2: gpr.value = gpr.data_word;
        3'h3: gpr.value = gpr.base_general_word;
        3'h4: gpr.value = gpr.stack_pointer_word;
        3'h5: gpr.value = gpr.base_pointer_word;
        3'h6: gpr.value = gpr.source_index_word;
        3'h7: gpr.value = gpr.destination_index_word;
      endcase
    end else begin
      // Byte slots: low halves first, then high halves, zero above
      unique case (gpr.slot)
        3'h0: low_byte = gpr.accumulator_word[7:0];
        3'h1: low_byte = gpr.count_word[7:0];
        3'h2: low_byte = gpr.data_word[7:0];
        3'h3: low_byte = gpr.base_general_word[7:0];
        3'h4: low_byte = gpr.accumulator_word[15:8];
        3'h5: low_byte = gpr.count_word[15:8];
        3'h6: low_byte = gpr.data_word[15:8];
        3'h7: low_byte = gpr.base_general_word[15:8];
      endcase
      gpr.value = {8'h00, low_byte};
    end
  end

endmodule : oad_reg_select

// ### shared/oad_gpr_if.sv
// Register-operand selection carrier between the decoder and its selector
`timescale 1ns/1ps
interface oad_gpr_if;
  logic [15:0] accumulator_word;
  logic [15:0] count_word;
  logic [15:0] data_word;
  logic [15:0] base_general_word;
  logic [15:0] stack_pointer_word;
  logic [15:0] base_pointer_word;
  logic [15:0] source_index_word;
  logic [15:0] destination_index_word;
  logic [2:0] slot;
  logic size_word;
  logic [15:0] value;

  modport src (
    output accumulator_word, count_word, data_word, base_general_word,
    output stack_pointer_word, base_pointer_word, source_index_word,
    output destination_index_word, slot, size_word,
    input value
  );
  modport sel (
    input accumulator_word, count_word, data_word, base_general_word,
    input stack_pointer_word, base_pointer_word, source_index_word,
    input destination_index_word, slot, size_word,
    output value
  );
endinterface : oad_gpr_if

// ### shared/oad_pkg.sv
// Constants and types shared by the operand address decoder
package oad_pkg;

  // ----------------------------------------------------------------
  // Addressing-form field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FORM_NO_DISP = 2'b00;
  localparam logic [1:0] FORM_DISP8 = 2'b01;
  localparam logic [1:0] FORM_DISP16 = 2'b10;
  localparam logic [1:0] FORM_REG = 2'b11;

  // ----------------------------------------------------------------
  // Operand-select codes and field positions in the form byte
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_BASE_SRC = 3'b000;
  localparam logic [2:0] SEL_BASE_DST = 3'b001;
  localparam logic [2:0] SEL_BP_SRC = 3'b010;
  localparam logic [2:0] SEL_BP_DST = 3'b011;
  localparam logic [2:0] SEL_SRC = 3'b100;
  localparam logic [2:0] SEL_DST = 3'b101;
  localparam logic [2:0] SEL_BP = 3'b110;
  localparam logic [2:0] SEL_BASE = 3'b111;
  localparam int FORM_MSB = 7;
  localparam int FORM_LSB = 6;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 0;

  // ----------------------------------------------------------------
  // Segment-override prefix: 001 ss 110
  // ----------------------------------------------------------------
  localparam logic [2:0] PREFIX_TOP = 3'b001;
  localparam logic [2:0] PREFIX_LOW = 3'b110;
  localparam int PREFIX_SEG_MSB = 4;
  localparam int PREFIX_SEG_LSB = 3;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CALC_CYCLES = 3'h4;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    OAD_SEG_EXTRA = 2'b00,
    OAD_SEG_CODE = 2'b01,
    OAD_SEG_STACK = 2'b10,
    OAD_SEG_DATA = 2'b11
  } oad_seg_t;

  typedef enum logic [2:0] {
    OAD_IDLE,
    OAD_DISP_LOW,
    OAD_DISP_HIGH,
    OAD_CALC
  } oad_state_t;

endpackage : oad_pkg

// ### verification/oad_decoder_props.sv
// Concurrent checks on the operand address decoder ports
`timescale 1ns/1ps
module oad_decoder_props (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic decode_start,
  input wire logic [7:0] form_byte,
  input wire logic string_dest,
  input wire logic prefix_valid,
  input wire logic [7:0] prefix_byte,
  input wire logic disp_valid,
  input wire logic disp_ready,
  input wire logic busy,
  input wire logic result_valid,
  input wire logic operand_is_register,
  input wire logic [1:0] segment_sel,
  input wire logic override_held
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Shadow of the accepted decode
  // ----------------------------------------------------------------
  logic st, pok, pv;
  logic [1:0] ps, es, nd, n;
  logic [1:0] f;
  assign f = form_byte[7:6];
  assign st = decode_start && !busy;
  assign pok = prefix_valid && !busy && !decode_start && prefix_byte[7:5] == 3'h1
    && prefix_byte[2:0] == 3'h6;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pv <= 1'b0;
      n <= 2'h0;
    end else if (st) begin
      pv <= 1'b0;
      n <= 2'h0;
      nd <= f == 2'h1 ? 2'h1 : (f == 2'h2 || f == 2'h0 && form_byte[2:0] == 3'h6) ? 2'h2 : 2'h0;
      es <= string_dest ? 2'h0 : pv ? ps : (form_byte[2:1] == 2'h1
        || form_byte[2:0] == 3'h6 && f != 2'h0) ? 2'h2 : 2'h3;
    end else begin
      if (pok) pv <= 1'b1;
      if (pok) ps <= prefix_byte[4:3];
      if (disp_valid && disp_ready) n <= n + 2'h1;
    end
  end
  property p_reg;
    st && f == 2'h3 |=> result_valid && operand_is_register;
  endproperty
  a_reg: assert property (p_reg) else $error("register form result late");
  property p_plain;
    st && f == 2'h0 && form_byte[2:0] != 3'h6 |=> (!disp_ready && !result_valid) [*4]
      ##1 result_valid;
  endproperty
  a_plain: assert property (p_plain) else $error("no-disp form timing");
  property p_calc;
    disp_valid && disp_ready ##1 !disp_ready |-> (busy && !result_valid) [*4] ##1 result_valid;
  endproperty
  a_calc: assert property (p_calc) else $error("calc not four cycles");
  property p_count;
    result_valid && !operand_is_register |-> n == nd;
  endproperty
  a_count: assert property (p_count) else $error("disp byte count");
  property p_seg;
    result_valid && !operand_is_register |-> segment_sel == es;
  endproperty
  a_seg: assert property (p_seg) else $error("wrong segment");
  property p_seg_reg;
    result_valid && operand_is_register |-> $stable(segment_sel);
  endproperty
  a_seg_reg: assert property (p_seg_reg) else $error("register form moved segment");
  property p_ovr;
    pok |=> override_held;
  endproperty
  a_ovr: assert property (p_ovr) else $error("prefix not held");
  property p_ready;
    st && f != 2'h3 |=> busy && disp_ready == (nd != 2'h0);
  endproperty
  a_ready: assert property (p_ready) else $error("disp fetch not next");
  c_reg: cover property (st && f == 2'h3);
  c_direct: cover property (st && f == 2'h0 && form_byte[2:0] == 3'h6);
  c_ovr: cover property (pok ##1 st);
endmodule : oad_decoder_props
bind oad_decoder oad_decoder_props oad_decoder_props_inst (
  .core_clk(core_clk), .sys_rst(sys_rst), .decode_start(decode_start),
  .form_byte(form_byte), .string_dest(string_dest), .prefix_valid(prefix_valid),
  .prefix_byte(prefix_byte), .disp_valid(disp_valid), .disp_ready(disp_ready),
  .busy(busy), .result_valid(result_valid), .operand_is_register(operand_is_register),
  .segment_sel(segment_sel), .override_held(override_held));

// ### verification/oad_fetch_model.sv
// Fetch-queue model offering displacement bytes on a valid/ready pair
`timescale 1ns/1ps
module oad_fetch_model (
  input wire logic core_clk,
  input wire logic disp_ready,
  output logic disp_valid,
  output logic [7:0] disp_byte
);
  logic [7:0] qb[$];
  int qw[$];
  int gap;
  task automatic push(input logic [7:0] b, input int w);
    qb.push_back(b);
    qw.push_back(w);
  endtask : push
  // Released lane shows the inverse so a stale byte cannot pass
  initial begin
    disp_valid = 1'b0;
    disp_byte = 8'h00;
    gap = 0;
    forever begin
      @(posedge core_clk);
      if (disp_valid && disp_ready) begin
        #1 disp_valid = 1'b0;
        disp_byte = ~disp_byte;
      end else if (!disp_valid && qb.size() > 0) begin
        if (gap < qw[0]) begin
          gap++;
        end else begin
          #1 disp_valid = 1'b1;
          disp_byte = qb.pop_front();
          void'(qw.pop_front());
          gap = 0;
        end
      end
    end
  end
endmodule : oad_fetch_model

// ### verification/operand_address_decoder_tb.sv
// Self-checking bench for the operand address decoder
`timescale 1ns/1ps
module operand_address_decoder_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic decode_start = 1'b0;
  logic [7:0] form_byte = 8'h00;
  logic size_word = 1'b0;
  logic string_dest = 1'b0;
  logic prefix_valid = 1'b0;
  logic [7:0] prefix_byte = 8'h00;
  logic disp_valid, busy, disp_ready, result_valid, operand_is_register, override_held;
  logic [7:0] disp_byte;
  logic [15:0] rf [8];
  logic [15:0] operand_offset, operand_value;
  logic [1:0] segment_sel;
  logic [31:0] seed = 32'hcd61_096d;
  logic [1:0] e_seg = 2'h3;
  logic [1:0] ps = 2'h0;
  logic pv = 1'b0;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 core_clk = ~core_clk;
  oad_decoder oad_decoder_inst (.core_clk(core_clk), .sys_rst(sys_rst),
    .decode_start(decode_start), .form_byte(form_byte), .size_word(size_word),
    .string_dest(string_dest), .prefix_valid(prefix_valid), .prefix_byte(prefix_byte),
    .disp_valid(disp_valid), .disp_byte(disp_byte), .accumulator_word(rf[0]),
    .count_word(rf[1]), .data_word(rf[2]), .base_general_word(rf[3]),
    .stack_pointer_word(rf[4]), .base_pointer_word(rf[5]), .source_index_word(rf[6]),
    .destination_index_word(rf[7]), .busy(busy), .disp_ready(disp_ready),
    .result_valid(result_valid), .operand_is_register(operand_is_register),
    .operand_offset(operand_offset), .operand_value(operand_value),
    .segment_sel(segment_sel), .override_held(override_held));
  oad_fetch_model oad_fetch_model_inst (.core_clk(core_clk), .disp_ready(disp_ready),
    .disp_valid(disp_valid), .disp_byte(disp_byte));
  // ----------------------------------------------------------------
  // Expectations and drivers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c1_1db7 : 32'h0000_0000);
  endfunction : lfsr
  function automatic logic [15:0] ea_of(input logic [7:0] fb, input logic [15:0] d);
    logic [15:0] x;
    x = fb[7:6] == 2'h1 ? {{8{d[7]}}, d[7:0]} : fb[7:6] == 2'h2 ? d : 16'h0000;
    case (fb[2:0])
      3'h0: return rf[3] + rf[6] + x;
      3'h1: return rf[3] + rf[7] + x;
      3'h2: return rf[5] + rf[6] + x;
      3'h3: return rf[5] + rf[7] + x;
      3'h4: return rf[6] + x;
      3'h5: return rf[7] + x;
      3'h6: return fb[7:6] == 2'h0 ? d : rf[5] + x;
      default: return rf[3] + x;
    endcase
  endfunction : ea_of
  function automatic logic [15:0] reg_of(input logic [2:0] s, input logic w);
    if (w) return rf[s];
    return s[2] ? {8'h00, rf[s[1:0]][15:8]} : {8'h00, rf[s[1:0]][7:0]};
  endfunction : reg_of
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic pref(input logic [7:0] b);
    @(posedge core_clk);
    #1 prefix_valid = 1'b1;
    prefix_byte = b;
    @(posedge core_clk);
    #1 prefix_valid = 1'b0;
    if (b[7:5] == 3'h1 && b[2:0] == 3'h6) begin
      pv = 1'b1;
      ps = b[4:3];
    end
    chk(override_held === pv, "prefix");
  endtask : pref
  task automatic run(input logic [7:0] fb, input logic w, input logic sd,
    input logic [15:0] d, input int gap);
    int nd;
    int t;
    nd = fb[7:6] == 2'h1 ? 1 : (fb[7:6] == 2'h2 || fb[7:6] == 2'h0 && fb[2:0] == 3'h6) ? 2 : 0;
    if (nd > 0) oad_fetch_model_inst.push(d[7:0], gap);
    if (nd > 1) oad_fetch_model_inst.push(d[15:8], gap);
    if (fb[7:6] != 2'h3) e_seg = sd ? 2'h0 : pv ? ps : (fb[2:1] == 2'h1
      || fb[2:0] == 3'h6 && fb[7:6] != 2'h0) ? 2'h2 : 2'h3;
    pv = 1'b0;
    @(posedge core_clk);
    #1 decode_start = 1'b1;
    form_byte = fb;
    size_word = w;
    string_dest = sd;
    @(posedge core_clk);
    #1 decode_start = 1'b0;
    t = 1;
    while (result_valid !== 1'b1 && t < 40) begin
      @(posedge core_clk);
      #1 t++;
    end
    chk(result_valid === 1'b1, "no result");
    if (fb[7:6] == 2'h3) begin
      chk(operand_is_register === 1'b1 && t == 1, "register form");
      chk(operand_value === reg_of(fb[2:0], w), "register value");
    end else begin
      chk(operand_is_register === 1'b0, "memory form");
      chk(operand_offset === ea_of(fb, d), "offset");
      if (nd == 0) chk(t == 5, "calc time");
    end
    chk(segment_sel === e_seg, "segment");
  endtask : run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Ceiling well above the roughly two and a half thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    foreach (rf[i]) rf[i] = 16'hffff;
    repeat (10) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk(busy === 1'b0 && segment_sel === 2'h3 && override_held === 1'b0, "reset");
    for (int i = 0; i < 4; i++) begin
      pref({3'h1, 2'(i), 3'h6});
      run(8'h02, 1'b1, 1'b0, 16'h0000, 0);
    end
    run(8'h80, 1'b1, 1'b0, 16'hffff, 0);
    run(8'h06, 1'b1, 1'b0, 16'h1234, 2);
    run(8'h44, 1'b1, 1'b0, 16'h0080, 1);
    pref(8'h3e);
    run(8'h85, 1'b1, 1'b1, 16'h8001, 0);
    pref(8'h27);
    run(8'hc5, 1'b0, 1'b0, 16'h0000, 0);
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      rf[seed[2:0]] = seed[31:16];
      rf[seed[12:10]] = seed[15:0];
      if (seed[5:4] == 2'h0) pref({seed[8] ? 3'h1 : seed[11:9], seed[14:13], 3'h6});
      run(seed[23:16], seed[6], seed[7] & seed[3], seed[31:16] ^ seed[15:0], int'(seed[9:8]));
    end
    test_done();
  end
endmodule : operand_address_decoder_tb
